// File: sar_seq_pkg.sv
// Constants and carrier types for the conversion sequencer
package sar_seq_pkg;

    // ------------------------------------------------------------
    // Conversion cycle
    // ------------------------------------------------------------
    localparam int unsigned RES_BITS      = 12;
    localparam logic [3:0]  PERIOD_FIRST  = 4'h1;
    localparam logic [3:0]  PERIOD_SECOND = 4'h2;
    localparam logic [3:0]  PERIOD_TRACK  = 4'h3;
    localparam logic [3:0]  PERIOD_MSB    = 4'h4;
    localparam logic [3:0]  PERIOD_LAST   = 4'hf;
    localparam int unsigned UPPER_LO      = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned ACLK_PERIOD_NS    = 10;
    localparam int unsigned INT_CLK_PERIOD_NS = 1334;
    localparam int unsigned INT_HALF_CYCLES   =
        (INT_CLK_PERIOD_NS / 2) / ACLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam int unsigned CTRL_EXT_CLK  = 0;
    localparam int unsigned CTRL_SOFT_REQ = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] period;
        logic       halted;
        logic       tracking;
        logic       valid;
    } status_t;

    typedef struct packed {
        logic [RES_BITS-1:0] data;
        logic [RES_BITS-1:0] oe;
    } result_pins_t;

endpackage

// File: sar_adc_conversion_sequencer.sv
// Successive-approximation conversion sequencer with AXI4-Lite registers
`timescale 1ns/100ps

module sar_adc_conversion_sequencer #(
    parameter int unsigned HALF_CYCLES = sar_seq_pkg::INT_HALF_CYCLES
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]                          s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [3:0]                          s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    // Converter pins
    input  wire logic                                conversion_request_n,
    input  wire logic                                upper_group_output_enable_n,
    input  wire logic                                lower_group_output_enable_n,
    input  wire logic                                clk_pin_i,
    output logic                                     clk_pin_o,
    output logic                                     clk_pin_oe,
    output sar_seq_pkg::result_pins_t                result_pins,
    output logic                                     result_valid_flag,
    // Analog front end
    input  wire logic                                comparator_i,
    output logic                                     track_o,
    output logic [sar_seq_pkg::RES_BITS-1:0]         dac_trial_o
);

    localparam int unsigned NB = sar_seq_pkg::RES_BITS;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_HALT = 2'b10
    } seq_state_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] req_sync_ff;
    logic [2:0] clk_sync_ff;
    logic       req_stable_ff;
    logic       clk_stable_ff;
    wire        req_agree = (req_sync_ff[1] == req_sync_ff[2]);
    wire        clk_agree = (clk_sync_ff[1] == clk_sync_ff[2]);
    wire        nxt_req_stable = req_agree ? req_sync_ff[2] : req_stable_ff;
    wire        nxt_clk_stable = clk_agree ? clk_sync_ff[2] : clk_stable_ff;
    wire        ext_rise = clk_agree & clk_sync_ff[2] & ~clk_stable_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_sync_ff   <= 3'h7;
            clk_sync_ff   <= 3'h0;
            req_stable_ff <= 1'b1;
            clk_stable_ff <= 1'b0;
        end else begin
            req_sync_ff   <= {req_sync_ff[1:0], conversion_request_n};
            clk_sync_ff   <= {clk_sync_ff[1:0], clk_pin_i};
            req_stable_ff <= nxt_req_stable;
            clk_stable_ff <= nxt_clk_stable;
        end
    end

    // ------------------------------------------------------------
    // Control register and request
    // ------------------------------------------------------------
    logic [1:0] ctrl_ff;
    wire        ext_clk_sel = ctrl_ff[sar_seq_pkg::CTRL_EXT_CLK];
    wire        req_active  = ~req_stable_ff | ctrl_ff[sar_seq_pkg::CTRL_SOFT_REQ];

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    seq_state_t     state_ff;
    logic [3:0]     period_ff;
    logic           armed_ff;
    logic           go_ff;
    logic           valid_ff;
    logic [NB-1:0]  sar_ff;
    logic [NB-1:0]  result_ff;

    // ------------------------------------------------------------
    // Internal oscillator
    // ------------------------------------------------------------
    logic [15:0] div_cnt_ff;
    logic        int_clk_ff;
    wire         osc_idle  = (state_ff == ST_HALT) & ~go_ff;
    wire         osc_park  = osc_idle & ~int_clk_ff;
    wire         div_wrap  = (div_cnt_ff == 16'(HALF_CYCLES - 1));
    wire         int_rise  = ~osc_park & div_wrap & ~int_clk_ff;
    wire         conv_edge = ext_clk_sel ? ext_rise : int_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_ff <= 16'h0000;
            int_clk_ff <= 1'b0;
        end else if (osc_park || ext_clk_sel) begin
            div_cnt_ff <= 16'h0000;
            int_clk_ff <= 1'b0;
        end else if (div_wrap) begin
            div_cnt_ff <= 16'h0000;
            int_clk_ff <= ~int_clk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
        end
    end

    assign clk_pin_o  = int_clk_ff;
    assign clk_pin_oe = ~ext_clk_sel;

    // ------------------------------------------------------------
    // Period sequencing
    // ------------------------------------------------------------
    wire in_last   = (period_ff == sar_seq_pkg::PERIOD_LAST);
    wire in_first  = (period_ff == sar_seq_pkg::PERIOD_FIRST);
    wire in_convert = (period_ff >= sar_seq_pkg::PERIOD_MSB);
    wire [3:0] bit_idx = sar_seq_pkg::PERIOD_LAST - period_ff;
    wire [NB-1:0] bit_mask = NB'(1) << bit_idx;
    wire [NB-1:0] keep_bit = comparator_i ? sar_ff : (sar_ff & ~bit_mask);
    wire [NB-1:0] nxt_trial = keep_bit | (bit_mask >> 1);
    wire run_edge  = conv_edge & (state_ff == ST_RUN);
    wire halt_go   = conv_edge & (state_ff == ST_HALT) & go_ff;
    wire req_halt  = (state_ff == ST_HALT) & req_active;

    seq_state_t nxt_state;
    logic [3:0] nxt_period;

    always_comb begin
        nxt_state  = state_ff;
        nxt_period = period_ff;
        if (run_edge) begin
            if (in_last) begin
                nxt_period = sar_seq_pkg::PERIOD_FIRST;
            end else if (in_first) begin
                nxt_period = sar_seq_pkg::PERIOD_SECOND;
                if (!(armed_ff || req_active)) begin
                    nxt_state = ST_HALT;
                end
            end else begin
                nxt_period = period_ff + 4'h1;
            end
        end else if (halt_go) begin
            nxt_state  = ST_RUN;
            nxt_period = sar_seq_pkg::PERIOD_TRACK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff  <= ST_HALT;
            period_ff <= sar_seq_pkg::PERIOD_SECOND;
        end else begin
            state_ff  <= nxt_state;
            period_ff <= nxt_period;
        end
    end

    // Requests only count in period 1 or while halted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_ff <= 1'b0;
            go_ff    <= 1'b0;
        end else begin
            if (run_edge) begin
                armed_ff <= 1'b0;
            end else if (in_first && state_ff == ST_RUN && req_active) begin
                armed_ff <= 1'b1;
            end
            if (halt_go) begin
                go_ff <= 1'b0;
            end else if (req_halt) begin
                go_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit decisions and result
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sar_ff    <= '0;
            result_ff <= '0;
        end else if (run_edge) begin
            if (period_ff == sar_seq_pkg::PERIOD_TRACK) begin
                sar_ff <= NB'(1) << (NB - 1);
            end else if (in_last) begin
                result_ff <= keep_bit;
                sar_ff    <= '0;
            end else if (in_convert) begin
                sar_ff <= nxt_trial;
            end
        end
    end

    // ------------------------------------------------------------
    // Result valid flag
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            valid_ff <= 1'b0;
        end else if (run_edge && in_last) begin
            valid_ff <= 1'b1;
        end else if (run_edge && in_first && (armed_ff || req_active)) begin
            valid_ff <= 1'b0;
        end else if (req_halt) begin
            valid_ff <= 1'b0;
        end
    end

    assign result_valid_flag = valid_ff;
    assign track_o = (period_ff <= sar_seq_pkg::PERIOD_TRACK);
    assign dac_trial_o = sar_ff;

    // ------------------------------------------------------------
    // Three-state result groups
    // ------------------------------------------------------------
    wire upper_on = ~upper_group_output_enable_n;
    wire lower_on = ~lower_group_output_enable_n;

    assign result_pins.data = result_ff;
    assign result_pins.oe   = {{(NB - sar_seq_pkg::UPPER_LO){upper_on}},
                               {sar_seq_pkg::UPPER_LO{lower_on}}};

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [3:0] aw_addr_ff;
    logic [1:0] wdat_ff;
    logic       wstrb0_ff;
    logic       bvalid_ff;
    logic [1:0] bresp_ff;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire wr_fire  = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire wr_ctrl  = wr_fire & (aw_addr_ff == sar_seq_pkg::OFS_CTRL);
    wire wr_known = (aw_addr_ff == sar_seq_pkg::OFS_CTRL) |
                    (aw_addr_ff == sar_seq_pkg::OFS_STATUS) |
                    (aw_addr_ff == sar_seq_pkg::OFS_RESULT);

    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= 4'h0;
            wdat_ff    <= 2'h0;
            wstrb0_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= sar_seq_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (w_take) begin
                w_got_ff  <= 1'b1;
                wdat_ff   <= s_axi_wdata[1:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_known ? sar_seq_pkg::RESP_OKAY : sar_seq_pkg::RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= sar_seq_pkg::CTRL_RESET;
        end else if (wr_ctrl && wstrb0_ff) begin
            ctrl_ff <= wdat_ff;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    sar_seq_pkg::status_t status;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    assign status.period   = period_ff;
    assign status.halted   = (state_ff == ST_HALT);
    assign status.tracking = track_o;
    assign status.valid    = valid_ff;

    wire [3:0] rd_addr  = {s_axi_araddr[3:2], 2'h0};
    wire       ar_take  = s_axi_arvalid & s_axi_arready;
    wire       rd_ctrl  = (rd_addr == sar_seq_pkg::OFS_CTRL);
    wire       rd_stat  = (rd_addr == sar_seq_pkg::OFS_STATUS);
    wire       rd_res   = (rd_addr == sar_seq_pkg::OFS_RESULT);
    wire [31:0] rd_word = rd_ctrl ? {30'h0, ctrl_ff} :
                          rd_stat ? {25'h0, status} :
                          rd_res  ? {20'h0, result_ff} : 32'h0;

    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= sar_seq_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= (rd_ctrl | rd_stat | rd_res) ?
                         sar_seq_pkg::RESP_OKAY : sar_seq_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule

// File: sar_seq_assertions.sv
// Checker for the conversion sequencer pins
`timescale 1ns/100ps
module sar_seq_assertions (
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire logic                      upper_group_output_enable_n,
    input wire logic                      lower_group_output_enable_n,
    input wire sar_seq_pkg::result_pins_t result_pins,
    input wire logic                      result_valid_flag,
    input wire logic                      track_o,
    input wire logic [11:0]               dac_trial_o
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // --------
    // Pins
    // --------
    AST_OE_UPPER: assert property (
        result_pins.oe[11:4] == {8{!upper_group_output_enable_n}})
        else $error("upper group enable wrong");
    AST_OE_LOWER: assert property (
        result_pins.oe[3:0] == {4{!lower_group_output_enable_n}})
        else $error("lower group enable wrong");
    AST_RISE_IN_TRACK: assert property ($rose(result_valid_flag) |-> track_o)
        else $error("flag rose outside period 1");
    AST_RISE_AFTER_HOLD: assert property (
        $rose(result_valid_flag) |-> !$past(track_o))
        else $error("flag rose without a hold phase");
    AST_DATA_ON_RISE: assert property (
        $changed(result_pins.data) |-> $rose(result_valid_flag))
        else $error("result changed outside period 1 entry");
    AST_TRIAL_MSB: assert property ($fell(track_o) |-> dac_trial_o == 12'h800)
        else $error("first trial code wrong");
    AST_FALL_IN_TRACK: assert property ($fell(result_valid_flag) |-> track_o)
        else $error("flag fell outside period 2");
    AST_HOLD_BOUND: assert property (
        $fell(track_o) |-> (!result_valid_flag throughout (##[43:299] 1'b1))
            ##1 $rose(result_valid_flag))
        else $error("conversion length wrong");
    AST_TRACK_MIN: assert property ($rose(track_o) |-> track_o[*4])
        else $error("tracking too short");
    // --------
    // Coverage
    // --------
    cover property ($rose(result_valid_flag));
    cover property ($fell(track_o));
    cover property (upper_group_output_enable_n && !lower_group_output_enable_n);
endmodule

// File: sar_input_model.sv
// Host side model: analog input and external result latch
`timescale 1ns/100ps
module sar_input_model (
    input  wire logic [11:0] dac_trial_o,
    input  wire logic [11:0] vin,
    input  wire logic        result_valid_flag,
    input  wire logic [11:0] data,
    input  wire logic [11:0] oe,
    output logic             comparator_i,
    output logic [11:0]      latched
);
    logic [11:0] bus_seen;
    // Straight binary compare
    assign comparator_i = (vin >= dac_trial_o);
    // Released bits show the inverse
    assign bus_seen = ~(data ^ oe);
    // Capture on flag fall
    always @(negedge result_valid_flag) latched <= bus_seen;
endmodule

// File: sar_adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module sar_adc_conversion_sequencer_tb;
    // --------
    // Signals
    // --------
    typedef struct packed {
        logic        ext;
        logic        sw;
        logic [11:0] vin;
    } row_t;
    localparam int hc = 2;
    logic                       aclk, aresetn, conversion_request_n;
    logic                       upper_group_output_enable_n, lower_group_output_enable_n;
    logic [3:0]                 s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]                s_axi_wdata, s_axi_rdata;
    logic [1:0]                 s_axi_bresp, s_axi_rresp;
    logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                       s_axi_rvalid, s_axi_rready, track_o, comparator_i;
    logic                       clk_pin_i, clk_pin_o, clk_pin_oe, result_valid_flag;
    logic [11:0]                dac_trial_o, vin, latched;
    sar_seq_pkg::result_pins_t  result_pins;
    int                         error_cnt, n_checks;
    row_t rows [7] = '{'{1'b0, 1'b0, 12'h000}, '{1'b0, 1'b0, 12'h001},
        '{1'b0, 1'b1, 12'h800}, '{1'b1, 1'b0, 12'hc00}, '{1'b1, 1'b1, 12'hfff},
        '{1'b0, 1'b0, 12'h400}, '{1'b0, 1'b0, 12'hffe}};
    // --------
    // Instances
    // --------
    sar_adc_conversion_sequencer #(.HALF_CYCLES(hc)) sar_adc_conversion_sequencer_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .conversion_request_n(conversion_request_n),
        .upper_group_output_enable_n(upper_group_output_enable_n),
        .lower_group_output_enable_n(lower_group_output_enable_n),
        .clk_pin_i(clk_pin_i), .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
        .result_pins(result_pins), .result_valid_flag(result_valid_flag),
        .comparator_i(comparator_i), .track_o(track_o), .dac_trial_o(dac_trial_o));
    sar_input_model sar_input_model_inst (.dac_trial_o(dac_trial_o), .vin(vin),
        .result_valid_flag(result_valid_flag), .data(result_pins.data), .oe(result_pins.oe),
        .comparator_i(comparator_i), .latched(latched));
    // --------
    // Tasks
    // --------
    task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t pin value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t register value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rsp);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rsp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        dt = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wt(input bit sel, input logic v);
        int n;
        n = 0;
        while ((sel ? track_o : result_valid_flag) !== v && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        if (n == 2000) begin
            error_cnt++;
            $display("MISMATCH %0t wait expired", $time);
        end
    endtask
    function automatic logic [31:0] st(input logic v);
        return {25'h0, sar_seq_pkg::PERIOD_SECOND, 1'b1, 1'b1, v};
    endfunction
    task final_report;
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // --------
    // Stimulus
    // --------
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    always begin
        repeat (3) @(posedge aclk);
        clk_pin_i <= ~clk_pin_i;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        final_report();
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        longint      t0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, clk_pin_i, vin} = '0;
        {upper_group_output_enable_n, lower_group_output_enable_n} = 2'h0;
        s_axi_wstrb = 4'hf;
        conversion_request_n = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_pin({11'h0, result_valid_flag}, 12'h000);
        axr(sar_seq_pkg::OFS_STATUS, d, r);
        chk_reg(d, st(1'b0));
        for (int i = 0; i < 7; i++) begin
            axw(sar_seq_pkg::OFS_CTRL, {30'h0, 1'b0, rows[i].ext}, r);
            vin <= rows[i].vin;
            if (rows[i].sw) axw(sar_seq_pkg::OFS_CTRL, {30'h0, 1'b1, rows[i].ext}, r);
            else conversion_request_n <= 1'b0;
            wt(1'b1, 1'b0);
            if (i > 0) chk_pin(latched, rows[i-1].vin);
            if (rows[i].sw) axw(sar_seq_pkg::OFS_CTRL, {30'h0, 1'b0, rows[i].ext}, r);
            else conversion_request_n <= 1'b1;
            wt(1'b0, 1'b1);
            chk_pin(result_pins.data, rows[i].vin);
            chk_pin(result_pins.oe, 12'hfff);
            axr(sar_seq_pkg::OFS_RESULT, d, r);
            chk_reg(d, {20'h0, rows[i].vin});
            repeat (60) @(posedge aclk);
            axr(sar_seq_pkg::OFS_STATUS, d, r);
            chk_reg(d, st(1'b1));
            chk_pin({10'h0, clk_pin_oe, clk_pin_o}, {10'h0, ~rows[i].ext, 1'b0});
        end
        axw(sar_seq_pkg::OFS_CTRL, 32'h0, r);
        conversion_request_n <= 1'b0;
        wt(1'b0, 1'b0);
        wt(1'b0, 1'b1);
        t0 = $time;
        wt(1'b0, 1'b0);
        wt(1'b0, 1'b1);
        chk_reg(32'(($time - t0) / 10), 32'(15 * 2 * hc));
        conversion_request_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            {upper_group_output_enable_n, lower_group_output_enable_n} <= 2'(k);
            @(posedge aclk);
            chk_pin(result_pins.oe, {{8{~k[1]}}, {4{~k[0]}}});
        end
        // Reset in mid conversion
        conversion_request_n <= 1'b0;
        wt(1'b1, 1'b0);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        conversion_request_n <= 1'b1;
        @(posedge aclk);
        @(posedge aclk);
        chk_pin(result_pins.data, 12'h000);
        chk_pin({11'h0, result_valid_flag}, 12'h000);
        axr(sar_seq_pkg::OFS_STATUS, d, r);
        chk_reg(d, st(1'b0));
        axw(sar_seq_pkg::OFS_STATUS, 32'hffff_ffff, r);
        chk_reg({30'h0, r}, {30'h0, sar_seq_pkg::RESP_OKAY});
        axr(4'hc, d, r);
        chk_reg({30'h0, r}, {30'h0, sar_seq_pkg::RESP_SLVERR});
        // Write with lane 0 disabled leaves control alone
        s_axi_wstrb <= 4'h0;
        axw(sar_seq_pkg::OFS_CTRL, 32'h0000_0003, r);
        s_axi_wstrb <= 4'hf;
        axr(sar_seq_pkg::OFS_CTRL, d, r);
        chk_reg(d, 32'h0000_0000);
        final_report();
    end
endmodule

bind sar_adc_conversion_sequencer sar_seq_assertions sar_seq_assertions_inst (.aclk(aclk),
    .aresetn(aresetn), .upper_group_output_enable_n(upper_group_output_enable_n),
    .lower_group_output_enable_n(lower_group_output_enable_n), .result_pins(result_pins),
    .result_valid_flag(result_valid_flag), .track_o(track_o), .dac_trial_o(dac_trial_o));
